// ==== hdl/acrb_pkg.sv ====
package acrb_pkg;
  // Bank-select codes as the host writes them
  localparam logic [7:0] BANK_ONE = 8'h02;
  localparam logic [7:0] BANK_TWO = 8'h10;
  localparam int NREG = 18;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Register offsets
  localparam logic [7:0] OFS_PAT_CTL_B = 8'h18;
  localparam logic [7:0] OFS_PAT_B_LO = 8'h19;
  localparam logic [7:0] OFS_PAT_B_MIX = 8'h1a;
  localparam logic [7:0] OFS_PAT_B_HI = 8'h1b;
  localparam logic [7:0] OFS_TAGS = 8'h1c;
  localparam logic [7:0] OFS_CAL_KEY = 8'h33;
  localparam logic [7:0] OFS_CAL_EXTRA = 8'h34;
  localparam logic [7:0] OFS_BW_PWR = 8'hc0;
  localparam logic [7:0] OFS_REF_FMT = 8'hc1;
  localparam logic [7:0] OFS_SPAN_LO = 8'hc2;
  localparam logic [7:0] OFS_SPAN_HI = 8'hc3;
  localparam logic [7:0] OFS_CM_PWR = 8'hc4;
  localparam logic [7:0] OFS_CM_MASTER = 8'hc5;
  localparam logic [7:0] OFS_STEP_ONE = 8'hf4;
  localparam logic [7:0] OFS_STEP_TWO = 8'hf6;
  localparam logic [7:0] OFS_B2_STEP_C = 8'h0a;
  localparam logic [7:0] OFS_B2_STEP_A = 8'h12;
  localparam logic [7:0] OFS_B2_STEP_B = 8'h13;
  // Entry order of the register file; bank and offset per entry
  localparam logic [7:0] REG_OFS [NREG] = '{
    OFS_PAT_CTL_B, OFS_PAT_B_LO, OFS_PAT_B_MIX, OFS_PAT_B_HI, OFS_TAGS,
    OFS_CAL_KEY, OFS_CAL_EXTRA, OFS_BW_PWR, OFS_REF_FMT, OFS_SPAN_LO,
    OFS_SPAN_HI, OFS_CM_PWR, OFS_CM_MASTER, OFS_STEP_ONE, OFS_STEP_TWO,
    OFS_B2_STEP_C, OFS_B2_STEP_A, OFS_B2_STEP_B};
  localparam int FIRST_BANK_TWO = 15;
  localparam int IX_PAT_CTL = 0;
  localparam int IX_PAT_LO = 1;
  localparam int IX_PAT_MIX = 2;
  localparam int IX_PAT_HI = 3;
  localparam int IX_TAGS = 4;
  localparam int IX_CAL_KEY = 5;
  localparam int IX_CAL_EXTRA = 6;
  localparam int IX_BW_PWR = 7;
  localparam int IX_REF_FMT = 8;
  localparam int IX_SPAN_LO = 9;
  localparam int IX_SPAN_HI = 10;
  localparam int IX_CM_PWR = 11;
  localparam int IX_CM_MASTER = 12;
  localparam int IX_STEP_ONE = 13;
  localparam int IX_STEP_TWO = 14;
  localparam int IX_B2_C = 15;
  localparam int IX_B2_A = 16;
  localparam int IX_B2_B = 17;
  // Field positions
  localparam int PAT_EN_BIT = 1;
  localparam int PAT_MODE_LO = 2;
  localparam int RAMP_INC_LO = 4;
  localparam int TAG_B_LO = 8;
  localparam int TAG_A_LO = 0;
  localparam int GCAL_THIRD_BIT = 13;
  localparam int GCAL_SECOND_BIT = 6;
  localparam int GCAL_FOURTH_BIT = 4;
  localparam int KEY_LO = 4;
  localparam int BW_LO = 2;
  localparam int CHSLEEP_LO = 0;
  localparam int REFSEL_BIT = 11;
  localparam int LANES_BIT = 9;
  localparam int RATE_BIT = 8;
  localparam int CMSPAN_B_LO = 8;
  localparam int CMSPAN_A_LO = 6;
  localparam int CMEN_LOW_GRP_BIT = 3;
  localparam int CMEN_HIGH_GRP_BIT = 2;
  localparam int CHIP_SLEEP_BIT = 0;
  localparam int CM_MASTER_BIT = 4;
  localparam int STEP_BIT = 1;
  localparam int B2_C_BIT = 14;
  localparam int B2_A_BIT = 6;
  localparam int B2_B_BIT = 15;
  // Field values
  localparam logic [1:0] KEY_OPEN = 2'h3;
  localparam logic [1:0] CM_SPAN_12V = 2'h2;
  localparam logic [3:0] LANES_TWO = 4'hf;
  localparam logic [3:0] LANES_ONE = 4'ha;
  localparam logic [7:0] CH_LOW_GRP = 8'h0f;
  localparam logic [7:0] CH_HIGH_GRP = 8'hf0;
  localparam logic [7:0] CH_ALL = 8'hff;
  localparam logic [7:0] CH_NONE = 8'h00;

  typedef enum logic [1:0] {
    PM_FIXED0 = 2'h0,
    PM_FIXED1 = 2'h1,
    PM_RAMP = 2'h2,
    PM_ALT = 2'h3
  } acrb_pat_mode_t;

  typedef struct packed {
    logic [2:0] gain_cal_on;
    logic init_unlocked;
    logic [4:0] init_steps;
    logic [7:0] input_bandwidth_select;
    logic [7:0] chan_asleep;
    logic whole_device_sleep;
    logic reference_source_select;
    logic [3:0] lane_on;
    logic single_rate;
    logic [31:0] span_codes;
    logic [1:0] grp_wide_cm;
    logic [3:0] grp_cm_span;
  } acrb_cfg_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [17:0] data;
  } acrb_samp_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [23:0] payload;
    logic [7:0] tag;
  } acrb_word_t;
endpackage

// ==== hdl/acrb_reg16.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_reg16 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);
  logic [15:0] q_r;

  // Reserved bits are stored too, so read-modify-write gets them back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_r <= acrb_pkg::REG_RESET;
    end else if (wr_en) begin
      q_r <= wdata;
    end
  end

  assign q = q_r;
endmodule // acrb_reg16
`default_nettype wire

// ==== hdl/acrb_pattern.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_pattern (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire acrb_pkg::acrb_pat_mode_t mode,
  input wire logic [3:0] ramp_inc,
  input wire logic [23:0] pat0,
  input wire logic [23:0] pat1,
  input wire logic advance,
  output logic [23:0] pattern
);
  logic [23:0] ramp_r;
  logic alt_r;

  // State restarts whenever the pattern is off, so each run begins alike
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ramp_r <= 24'h000000;
    end else if (!enable) begin
      ramp_r <= 24'h000000;
    end else if (advance && mode == acrb_pkg::PM_RAMP) begin
      ramp_r <= ramp_r + {20'h00000, ramp_inc} + 24'h000001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alt_r <= 1'b0;
    end else if (!enable) begin
      alt_r <= 1'b0;
    end else if (advance && mode == acrb_pkg::PM_ALT) begin
      alt_r <= !alt_r;
    end
  end

  always_comb begin
    case (mode)
      acrb_pkg::PM_FIXED0: pattern = pat0;
      acrb_pkg::PM_FIXED1: pattern = pat0;
      acrb_pkg::PM_RAMP: pattern = ramp_r;
      acrb_pkg::PM_ALT: pattern = alt_r ? pat1 : pat0;
      default: pattern = pat0;
    endcase
  end
endmodule // acrb_pattern
`default_nettype wire

// ==== hdl/acrb_bank_one.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_bank_one (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_bank,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  input wire logic samp_valid,
  input wire acrb_pkg::acrb_samp_t samp,
  output logic out_valid,
  output acrb_pkg::acrb_word_t out_word,
  output acrb_pkg::acrb_cfg_t cfg
);
  logic [15:0] regs [acrb_pkg::NREG];
  logic [acrb_pkg::NREG-1:0] hit;
  logic [15:0] rd_mux;
  logic [15:0] reg_rdata_r;
  logic reg_rvalid_r;
  acrb_pkg::acrb_cfg_t cfg_nxt;
  acrb_pkg::acrb_cfg_t cfg_r;
  logic [23:0] pat0;
  logic [23:0] pat1;
  logic [23:0] pattern;
  logic pat_en;
  acrb_pkg::acrb_pat_mode_t pat_mode;
  logic [3:0] ramp_inc;
  logic [15:0] cal_key;
  logic [15:0] bw_pwr;
  logic [15:0] ref_fmt;
  logic [15:0] cm_pwr;
  logic [1:0] chsleep_code;
  logic [7:0] group_sleep;
  logic cm_master;
  logic samp_is_b;
  logic samp_asleep;
  logic pat_advance;
  logic [7:0] tag_sel;
  logic [23:0] payload_sel;
  logic out_valid_r;
  acrb_pkg::acrb_word_t out_word_r;

  // Address decode: the bank selected by the host picks which table entries answer (0-14 or 15-17)
  genvar gi;
  generate
    for (gi = 0; gi < acrb_pkg::NREG; gi++) begin : g_reg
      logic bank_ok;
      assign bank_ok = (gi < acrb_pkg::FIRST_BANK_TWO) ?
                       (reg_bank == acrb_pkg::BANK_ONE) :
                       (reg_bank == acrb_pkg::BANK_TWO);
      assign hit[gi] = bank_ok && (reg_addr == acrb_pkg::REG_OFS[gi]);
      acrb_reg16 u_reg (
        .mclk(mclk),
        .rst(rst),
        .wr_en(reg_wr && hit[gi]),
        .wdata(reg_wdata),
        .q(regs[gi])
      );
    end
  endgenerate

  assign reg_hit = |hit;

  // Unmapped addresses and other banks read as zero
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < acrb_pkg::NREG; i++) begin
      if (hit[i]) begin
        rd_mux = regs[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;

  // Pattern words are split across three registers
  assign pat0 = {regs[acrb_pkg::IX_PAT_MIX][7:0], regs[acrb_pkg::IX_PAT_LO]};
  assign pat1 = {regs[acrb_pkg::IX_PAT_HI], regs[acrb_pkg::IX_PAT_MIX][15:8]};
  assign pat_en = regs[acrb_pkg::IX_PAT_CTL][acrb_pkg::PAT_EN_BIT];
  assign pat_mode = acrb_pkg::acrb_pat_mode_t'(
    regs[acrb_pkg::IX_PAT_CTL][acrb_pkg::PAT_MODE_LO +: 2]);
  assign ramp_inc = regs[acrb_pkg::IX_PAT_CTL][acrb_pkg::RAMP_INC_LO +: 4];

  assign cal_key = regs[acrb_pkg::IX_CAL_KEY];
  assign bw_pwr = regs[acrb_pkg::IX_BW_PWR];
  assign ref_fmt = regs[acrb_pkg::IX_REF_FMT];
  assign cm_pwr = regs[acrb_pkg::IX_CM_PWR];
  assign chsleep_code = bw_pwr[acrb_pkg::CHSLEEP_LO +: 2];
  assign cm_master = regs[acrb_pkg::IX_CM_MASTER][acrb_pkg::CM_MASTER_BIT];

  always_comb begin
    case (chsleep_code)
      2'h0: group_sleep = acrb_pkg::CH_NONE;
      2'h1: group_sleep = acrb_pkg::CH_LOW_GRP;
      2'h2: group_sleep = acrb_pkg::CH_HIGH_GRP;
      2'h3: group_sleep = acrb_pkg::CH_ALL;
      default: group_sleep = acrb_pkg::CH_NONE;
    endcase
  end

  // Decoded configuration for the analog and output stages
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.gain_cal_on = {
      regs[acrb_pkg::IX_CAL_EXTRA][acrb_pkg::GCAL_FOURTH_BIT],
      cal_key[acrb_pkg::GCAL_THIRD_BIT],
      cal_key[acrb_pkg::GCAL_SECOND_BIT]};
    // Only the exact key opens the sequence; partial keys count as locked
    cfg_nxt.init_unlocked = (cal_key[acrb_pkg::KEY_LO +: 2] == acrb_pkg::KEY_OPEN);
    cfg_nxt.init_steps = {
      regs[acrb_pkg::IX_B2_C][acrb_pkg::B2_C_BIT],
      regs[acrb_pkg::IX_B2_B][acrb_pkg::B2_B_BIT],
      regs[acrb_pkg::IX_B2_A][acrb_pkg::B2_A_BIT],
      regs[acrb_pkg::IX_STEP_TWO][acrb_pkg::STEP_BIT],
      regs[acrb_pkg::IX_STEP_ONE][acrb_pkg::STEP_BIT]};
    cfg_nxt.input_bandwidth_select = bw_pwr[acrb_pkg::BW_LO +: 8];
    cfg_nxt.whole_device_sleep = cm_pwr[acrb_pkg::CHIP_SLEEP_BIT];
    if (cm_pwr[acrb_pkg::CHIP_SLEEP_BIT]) begin
      cfg_nxt.chan_asleep = acrb_pkg::CH_ALL;
    end else begin
      cfg_nxt.chan_asleep = group_sleep;
    end
    cfg_nxt.reference_source_select = ref_fmt[acrb_pkg::REFSEL_BIT];
    if (ref_fmt[acrb_pkg::LANES_BIT]) begin
      cfg_nxt.lane_on = acrb_pkg::LANES_ONE;
    end else begin
      cfg_nxt.lane_on = acrb_pkg::LANES_TWO;
    end
    cfg_nxt.single_rate = ref_fmt[acrb_pkg::RATE_BIT];
    cfg_nxt.span_codes = {regs[acrb_pkg::IX_SPAN_HI], regs[acrb_pkg::IX_SPAN_LO]};
    if (cm_master) begin
      cfg_nxt.grp_wide_cm = {cm_pwr[acrb_pkg::CMEN_HIGH_GRP_BIT],
                             cm_pwr[acrb_pkg::CMEN_LOW_GRP_BIT]};
      cfg_nxt.grp_cm_span = {cm_pwr[acrb_pkg::CMSPAN_B_LO +: 2],
                             cm_pwr[acrb_pkg::CMSPAN_A_LO +: 2]};
    end else begin
      cfg_nxt.grp_wide_cm = 2'h3;
      cfg_nxt.grp_cm_span = {acrb_pkg::CM_SPAN_12V, acrb_pkg::CM_SPAN_12V};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg = cfg_r;

  // Sample path: tag, pattern substitution and sleep gating
  assign samp_is_b = samp.chan[2];
  assign samp_asleep = cfg_nxt.chan_asleep[samp.chan];
  // One pattern step per converter-B frame, so all four channels match
  assign pat_advance = samp_valid && pat_en && (samp.chan == 3'h7);

  acrb_pattern u_pattern (
    .mclk(mclk),
    .rst(rst),
    .enable(pat_en),
    .mode(pat_mode),
    .ramp_inc(ramp_inc),
    .pat0(pat0),
    .pat1(pat1),
    .advance(pat_advance),
    .pattern(pattern)
  );

  always_comb begin
    if (samp_is_b) begin
      tag_sel = regs[acrb_pkg::IX_TAGS][acrb_pkg::TAG_B_LO +: 8];
    end else begin
      tag_sel = regs[acrb_pkg::IX_TAGS][acrb_pkg::TAG_A_LO +: 8];
    end
  end

  always_comb begin
    if (samp_is_b && pat_en) begin
      payload_sel = pattern;
    end else begin
      payload_sel = {{6{samp.data[17]}}, samp.data};
    end
  end

  // A sleeping channel produces nothing rather than stale data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= samp_valid && !samp_asleep;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_word_r <= '0;
    end else if (samp_valid && !samp_asleep) begin
      out_word_r.chan <= samp.chan;
      out_word_r.payload <= payload_sel;
      out_word_r.tag <= tag_sel;
    end
  end

  assign out_valid = out_valid_r;
  assign out_word = out_word_r;
endmodule // acrb_bank_one
`default_nettype wire

// ==== sim/acrb_bank_one_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_bank_one_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_bank,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  input wire logic samp_valid,
  input wire acrb_pkg::acrb_samp_t samp,
  input wire logic out_valid,
  input wire acrb_pkg::acrb_word_t out_word,
  input wire acrb_pkg::acrb_cfg_t cfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Decoded config lags the register by one edge, so it is judged two edges on
  sequence s_cfg_wr(ofs);
    reg_wr && reg_hit && reg_addr == ofs ##2 1'b1;
  endsequence
  sequence s_wr_rd;
    reg_wr && reg_hit ##2 reg_rd && !reg_wr && !$past(reg_wr)
      && reg_addr == $past(reg_addr, 2) && reg_bank == $past(reg_bank, 2);
  endsequence
  AST_READBACK: assert property (s_wr_rd |=>
    reg_rvalid && reg_rdata == $past(reg_wdata, 3)) else $error("readback differs");
  AST_MISS_ZERO: assert property (reg_rd && !reg_hit |=>
    reg_rvalid && reg_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_RVALID_ONE: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without read");
  AST_GAIN: assert property (s_cfg_wr(acrb_pkg::OFS_CAL_KEY) |->
    cfg.gain_cal_on[1:0] == {$past(reg_wdata[13], 2), $past(reg_wdata[6], 2)}
    && cfg.init_unlocked == ($past(reg_wdata[5:4], 2) == 2'h3)) else $error("gain or key");
  AST_BW: assert property (s_cfg_wr(acrb_pkg::OFS_BW_PWR) |->
    cfg.input_bandwidth_select == $past(reg_wdata[9:2], 2)) else $error("bandwidth");
  AST_FORMAT: assert property (s_cfg_wr(acrb_pkg::OFS_REF_FMT) |->
    cfg.reference_source_select == $past(reg_wdata[11], 2)
    && cfg.single_rate == $past(reg_wdata[8], 2)
    && cfg.lane_on == ($past(reg_wdata[9], 2) ? acrb_pkg::LANES_ONE : acrb_pkg::LANES_TWO))
    else $error("output format");
  AST_SPAN: assert property (s_cfg_wr(acrb_pkg::OFS_SPAN_HI) |->
    cfg.span_codes[31:16] == $past(reg_wdata, 2)) else $error("span codes");
  AST_CM_FORCED: assert property (s_cfg_wr(acrb_pkg::OFS_CM_MASTER) |->
    $past(reg_wdata[4], 2) || (cfg.grp_wide_cm == 2'h3 && cfg.grp_cm_span == 4'ha))
    else $error("common mode not forced");
  AST_DROP: assert property (samp_valid && !$past(reg_wr) &&
    (cfg.whole_device_sleep || cfg.chan_asleep[samp.chan]) |=> !out_valid)
    else $error("sleeping channel passed");
  AST_PASS: assert property (samp_valid && !$past(reg_wr) && !cfg.whole_device_sleep &&
    !cfg.chan_asleep[samp.chan] |=> out_valid && out_word.chan == $past(samp.chan))
    else $error("sample lost");
endmodule // acrb_bank_one_properties
bind acrb_bank_one acrb_bank_one_properties i_props (.mclk(mclk), .rst(rst),
  .reg_bank(reg_bank), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
  .samp_valid(samp_valid), .samp(samp), .out_valid(out_valid), .out_word(out_word), .cfg(cfg));
`default_nettype wire

// ==== sim/acrb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_host_model (
  input wire logic mclk,
  output var logic [7:0] reg_bank,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [7:0] reg_addr,
  output var logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_bank = acrb_pkg::BANK_ONE;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 16'hffff;
  end
  // Bank goes with every access; the callers keep reserved bits at zero
  task automatic wr(input logic [7:0] bank, input logic [7:0] ofs, input logic [15:0] data);
    @(posedge mclk);
    reg_bank <= bank;
    reg_addr <= ofs;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~data;
  endtask
  task automatic rd(input logic [7:0] bank, input logic [7:0] ofs, output logic [15:0] data,
      output logic ok);
    @(posedge mclk);
    reg_bank <= bank;
    reg_addr <= ofs;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~ofs;
    #1;
    ok = reg_rvalid;
    data = reg_rdata;
  endtask
endmodule // acrb_host_model
`default_nettype wire

// ==== sim/acrb_bank_one_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module acrb_bank_one_tb;
  logic mclk, rst, reg_wr, reg_rd, reg_rvalid, reg_hit, samp_valid, out_valid, rok;
  logic [7:0] reg_bank, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rdat;
  acrb_pkg::acrb_samp_t samp;
  acrb_pkg::acrb_word_t out_word;
  acrb_pkg::acrb_cfg_t cfg;
  int errors, comparisons;
  // Only documented field bits per register entry
  localparam logic [15:0] FMASK [acrb_pkg::NREG] = '{16'h00fe, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'h2070, 16'h0010, 16'h03ff, 16'h0b00, 16'hffff, 16'hffff, 16'h03cd, 16'h0010,
    16'h0002, 16'h0002, 16'h4000, 16'h0040, 16'h8000};
  acrb_bank_one i_dut (.mclk(mclk), .rst(rst), .reg_bank(reg_bank), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .samp_valid(samp_valid), .samp(samp),
    .out_valid(out_valid), .out_word(out_word), .cfg(cfg));
  acrb_host_model i_host (.mclk(mclk), .reg_bank(reg_bank), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] bank_of(input int i);
    return (i >= acrb_pkg::FIRST_BANK_TWO) ? acrb_pkg::BANK_TWO : acrb_pkg::BANK_ONE;
  endfunction
  task automatic regchk(input logic [7:0] bank, input logic [7:0] ofs, input logic [15:0] exp);
    i_host.rd(bank, ofs, rdat, rok);
    chk(rok, 1'b1, "read valid");
    chk(rdat, exp, "read data");
  endtask
  task automatic wr1(input logic [7:0] ofs, input logic [15:0] data);
    i_host.wr(acrb_pkg::BANK_ONE, ofs, data);
  endtask
  task automatic send(input logic [2:0] ch, input logic [17:0] d, input logic vld,
      input logic [23:0] pay, input logic [7:0] tg);
    @(posedge mclk);
    samp_valid <= 1'b1;
    samp <= {ch, d};
    @(posedge mclk);
    samp_valid <= 1'b0;
    samp <= ~{ch, d};
    #1;
    chk(out_valid, vld, "sample valid");
    if (vld) chk(out_word, {ch, pay, tg}, "output word");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("wrong value at %0t: run hung", $time);
    tally_and_finish();
  end
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    samp_valid = 1'b0;
    samp = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < acrb_pkg::NREG; i++) regchk(bank_of(i), acrb_pkg::REG_OFS[i], 16'h0000);
    chk(cfg.lane_on, acrb_pkg::LANES_TWO, "lanes after reset");
    chk(cfg.grp_cm_span, 4'ha, "common span after reset");
    $display("test reset values done");
    for (int i = 0; i < acrb_pkg::NREG; i++) begin
      i_host.wr(bank_of(i), acrb_pkg::REG_OFS[i], FMASK[i]);
      regchk(bank_of(i), acrb_pkg::REG_OFS[i], FMASK[i]);
      i_host.wr(bank_of(i), acrb_pkg::REG_OFS[i], 16'h0000);
      regchk(bank_of(i), acrb_pkg::REG_OFS[i], 16'h0000);
    end
    $display("test field readback done");
    wr1(acrb_pkg::OFS_CAL_EXTRA, 16'h0010);
    @(posedge mclk);
    #1;
    chk(cfg.gain_cal_on, 3'h4, "fourth gain switch");
    i_host.wr(acrb_pkg::BANK_TWO, acrb_pkg::OFS_B2_STEP_C, 16'h4000);
    @(posedge mclk);
    #1;
    chk(cfg.init_steps, 5'h10, "bank two step flag");
    i_host.wr(acrb_pkg::BANK_TWO, acrb_pkg::OFS_B2_STEP_C, 16'h0000);
    wr1(acrb_pkg::OFS_CAL_EXTRA, 16'h0000);
    wr1(acrb_pkg::OFS_PAT_B_LO, 16'h3456);
    chk(reg_hit, 1'b1, "mapped hit");
    i_host.wr(8'h00, acrb_pkg::OFS_PAT_B_LO, 16'hffff);
    chk(reg_hit, 1'b0, "bank zero miss");
    wr1(8'h20, 16'hffff);
    regchk(acrb_pkg::BANK_ONE, 8'h20, 16'h0000);
    regchk(acrb_pkg::BANK_ONE, acrb_pkg::OFS_PAT_B_LO, 16'h3456);
    $display("test unmapped access done");
    wr1(acrb_pkg::OFS_TAGS, 16'h5a3c);
    send(3'h1, 18'h3ffff, 1'b1, 24'hffffff, 8'h3c);
    send(3'h5, 18'h00123, 1'b1, 24'h000123, 8'h5a);
    wr1(acrb_pkg::OFS_PAT_B_MIX, 16'hbc12);
    wr1(acrb_pkg::OFS_PAT_B_HI, 16'h789a);
    wr1(acrb_pkg::OFS_PAT_CTL_B, 16'h0002);
    send(3'h4, 18'h00077, 1'b1, 24'h123456, 8'h5a);
    send(3'h0, 18'h00077, 1'b1, 24'h000077, 8'h3c);
    wr1(acrb_pkg::OFS_PAT_CTL_B, 16'h000e);
    send(3'h7, 18'h00000, 1'b1, 24'h123456, 8'h5a);
    send(3'h7, 18'h00000, 1'b1, 24'h789abc, 8'h5a);
    // Ramp with step one: each channel-7 sample moves the ramp by two
    wr1(acrb_pkg::OFS_PAT_CTL_B, 16'h001a);
    send(3'h7, 18'h00000, 1'b1, 24'h000000, 8'h5a);
    send(3'h7, 18'h00000, 1'b1, 24'h000002, 8'h5a);
    wr1(acrb_pkg::OFS_PAT_CTL_B, 16'h0000);
    $display("test pattern and tags done");
    for (int c = 0; c < 4; c++) begin
      wr1(acrb_pkg::OFS_BW_PWR, 16'(c));
      send(3'h2, 18'h00011, !c[0], 24'h000011, 8'h3c);
      send(3'h6, 18'h00011, !c[1], 24'h000011, 8'h5a);
    end
    wr1(acrb_pkg::OFS_BW_PWR, 16'h0000);
    wr1(acrb_pkg::OFS_CM_PWR, 16'h0001);
    send(3'h0, 18'h00005, 1'b0, 24'h000005, 8'h3c);
    wr1(acrb_pkg::OFS_CM_PWR, 16'h0000);
    send(3'h0, 18'h00005, 1'b1, 24'h000005, 8'h3c);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule // acrb_bank_one_tb
`default_nettype wire
